// *** core/btd_counters.sv ***
`timescale 1ns/1ps

// Function
// - Every time and day counter is held as packed BCD, tens high and units low.
// - Seconds live at 08h in bits 6..0 as BCD 0 to 59.
// - Minutes live at 09h in bits 6..0 as BCD 0 to 59.
// - Hours bit 6 at 0Ah selects 24-hour (0) or 12-hour (1) counting.
// - In 12-hour mode bit 5 is the meridiem flag and bits 4..0 hold 1-12.
// - In 24-hour mode bits 5..0 hold the hour as BCD 0 to 23.
// - Day of month lives at 0Bh in bits 5..0 as BCD 1 to 31.
// - February gets a 29th day when the year is divisible by 4, 00 too.
// - Unused bit positions read back as zero.
module btd_counters
  import btd_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] MONTH_BCD,
  input wire logic [7:0] YEAR_BCD,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic SEC_TICK
);

  // ---------------------------------------------------------------
  // bcd helpers
  // ---------------------------------------------------------------
  // bcd increment
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // leap year: tens even and units 0/4/8, or tens odd and 2/6
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[1:0] == 2'b00);
    end
  endfunction

  // last day of the month in bcd
  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    if (m == MON_FEB) begin
      last_day = is_leap(y) ? BCD_29 : BCD_28;
    end else if (m == MON_APR || m == MON_JUN || m == MON_SEP ||
                 m == MON_NOV) begin
      last_day = BCD_30;
    end else begin
      last_day = BCD_31;
    end
  endfunction

  // ---------------------------------------------------------------
  // one-second prescaler
  // ---------------------------------------------------------------
  logic [31:0] pre_q, pre_d;
  logic tick_q, tick_d;

  // counts system clocks up to one second
  always_comb begin
    pre_d = pre_q;
    tick_d = 1'b0;
    if (CE) begin
      if (pre_q == 32'(TICK_COUNT - 1)) begin
        pre_d = 32'h0;
        tick_d = 1'b1;
      end else begin
        pre_d = pre_q + 32'h1;
      end
    end else begin
      tick_d = tick_q;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pre_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // time counters
  // ---------------------------------------------------------------
  btd_time_t t_q, t_d;
  logic fmt12;
  logic [7:0] hr12;
  logic [7:0] hr_nxt;
  logic hr_wrap;
  logic [7:0] hr12_inc;
  logic [7:0] hr24_inc;

  assign fmt12 = t_q.hr[HR_FMT_BIT];
  assign hr12 = {3'h0, t_q.hr[4:0]};
  // incremented hour in each format, sliced where used
  assign hr12_inc = bcd_inc(hr12);
  assign hr24_inc = bcd_inc({2'b00, t_q.hr[5:0]});

  // next hour value and day carry for either format
  always_comb begin
    hr_nxt = t_q.hr;
    hr_wrap = 1'b0;
    if (fmt12) begin
      if (hr12 == BCD_12) begin
        hr_nxt = {t_q.hr[7:5], BCD_01[4:0]};
      end else if (hr12 == BCD_11) begin
        hr_nxt = {t_q.hr[7:6], ~t_q.hr[HR_MER_BIT], BCD_12[4:0]};
        hr_wrap = t_q.hr[HR_MER_BIT];
      end else begin
        hr_nxt = {t_q.hr[7:5], hr12_inc[4:0]};
      end
    end else begin
      if ({2'b00, t_q.hr[5:0]} == BCD_23) begin
        hr_nxt = {t_q.hr[7:6], BCD_00[5:0]};
        hr_wrap = 1'b1;
      end else begin
        hr_nxt = {t_q.hr[7:6], hr24_inc[5:0]};
      end
    end
  end

  // counting with host writes overriding the addressed byte
  always_comb begin
    t_d = t_q;
    if (CE) begin
      if (tick_q) begin
        if (t_q.sec == BCD_59) begin
          t_d.sec = BCD_00;
          if (t_q.min == BCD_59) begin
            t_d.min = BCD_00;
            t_d.hr = hr_nxt;
            if (hr_wrap) begin
              if (t_q.day >= last_day(MONTH_BCD, YEAR_BCD)) begin
                t_d.day = BCD_01;
              end else begin
                t_d.day = bcd_inc(t_q.day);
              end
            end
          end else begin
            t_d.min = bcd_inc(t_q.min);
          end
        end else begin
          t_d.sec = bcd_inc(t_q.sec);
        end
      end
      // hour data is stored as written with bit 7 cleared
      if (WR_EN) begin
        case (ADDR)
          ADDR_SECONDS: t_d.sec = WDATA & MASK_SEC;
          ADDR_MINUTES: t_d.min = WDATA & MASK_SEC;
          ADDR_HOURS: t_d.hr = WDATA & MASK_HR;
          ADDR_DAYS: t_d.day = WDATA & MASK_DAY;
          default: t_d = t_d;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      t_q <= '{sec: RST_SEC, min: RST_SEC, hr: RST_HR, day: RST_DAY};
    end else begin
      t_q <= t_d;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // registered read, unused bits forced low
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = rvalid_q;
    if (CE) begin
      rvalid_d = RD_EN;
      if (RD_EN) begin
        case (ADDR)
          ADDR_SECONDS: rdata_d = t_q.sec & MASK_SEC;
          ADDR_MINUTES: rdata_d = t_q.min & MASK_SEC;
          // meridiem and format read back with hour
          ADDR_HOURS: rdata_d = t_q.hr & MASK_HR;
          ADDR_DAYS: rdata_d = t_q.day & MASK_DAY;
          default: rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign RDATA = rdata_q;
  assign RVALID = rvalid_q;
  assign SEC_TICK = tick_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sec_range_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (t_q.sec[3:0] <= 4'h9) && (t_q.sec <= BCD_59))
    else $error("seconds out of bcd range");
  min_wrap_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && tick_q && !WR_EN && t_q.sec == BCD_59 && t_q.min == BCD_59)
      |=> (t_q.min == BCD_00))
    else $error("minutes did not wrap");
  sec_step_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && tick_q && !WR_EN && t_q.sec == 8'h09) |=> (t_q.sec == 8'h10))
    else $error("seconds bcd carry wrong");
  hr12_wrap_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && tick_q && !WR_EN && fmt12 && hr12 == BCD_12 &&
     t_q.sec == BCD_59 && t_q.min == BCD_59)
      |=> (t_q.hr[4:0] == BCD_01[4:0] &&
           $stable(t_q.hr[HR_MER_BIT])))
    else $error("12 to 1 step wrong");
  mer_toggle_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && tick_q && !WR_EN && fmt12 && hr12 == BCD_11 &&
     t_q.sec == BCD_59 && t_q.min == BCD_59)
      |=> (t_q.hr[HR_MER_BIT] != $past(t_q.hr[HR_MER_BIT])))
    else $error("meridiem did not toggle");
  hr24_wrap_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && tick_q && !WR_EN && !fmt12 && t_q.hr[5:0] == BCD_23[5:0] &&
     t_q.sec == BCD_59 && t_q.min == BCD_59)
      |=> (t_q.hr[5:0] == 6'h00 && t_q.day != $past(t_q.day)))
    else $error("24-hour wrap wrong");
  leap_feb_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && tick_q && !WR_EN && hr_wrap && MONTH_BCD == MON_FEB &&
     YEAR_BCD == 8'h00 && t_q.day == BCD_28 &&
     t_q.sec == BCD_59 && t_q.min == BCD_59)
      |=> (t_q.day == BCD_29))
    else $error("year 00 not leap");
  rd_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && RD_EN && ADDR == ADDR_DAYS) |=> (RDATA[7:6] == 2'b00 && RVALID))
    else $error("unused day bits not zero");
  day_range_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && tick_q && !WR_EN && hr_wrap &&
     t_q.sec == BCD_59 && t_q.min == BCD_59)
      |=> (t_q.day != BCD_00 && t_q.day <= BCD_31 &&
           t_q.day[7:6] == 2'b00))
    else $error("day upper bits set");

endmodule

// *** core/btd_pkg.sv ***
package btd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SECONDS = 8'h08;
  localparam logic [7:0] ADDR_MINUTES = 8'h09;
  localparam logic [7:0] ADDR_HOURS = 8'h0a;
  localparam logic [7:0] ADDR_DAYS = 8'h0b;

  // ---------------------------------------------------------------
  // field layout and limits
  // ---------------------------------------------------------------
  localparam int HR_FMT_BIT = 6;
  localparam int HR_MER_BIT = 5;
  localparam logic [7:0] MASK_SEC = 8'h7f;
  localparam logic [7:0] MASK_HR = 8'h7f;
  localparam logic [7:0] MASK_DAY = 8'h3f;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_HR = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // time of day carried as one packed group
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] day;
  } btd_time_t;

endpackage

// *** testbench/btd_host.sv ***
`timescale 1ns/1ps

// ---------------------------------------------------------------
// host side of the register port
// ---------------------------------------------------------------
module btd_host (
  input wire logic CLK_SYS,
  input wire logic [7:0] RDATA,
  input wire logic RVALID,
  output logic CE,
  output logic WR_EN,
  output logic RD_EN,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA
);
  // idle bus at time zero, enable on until a freeze pulls it low
  initial begin
    CE = 1'b1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
  end

  // pull the clock enable low for n cycles, then restore it
  task automatic freeze(input int n);
    @(posedge CLK_SYS);
    CE <= 1'b0;
    repeat (n) @(posedge CLK_SYS);
    CE <= 1'b1;
  endtask

  // valid hours only
  // callers pass only hours legal for the chosen format;
  // lines go to the inverse once released so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    WR_EN <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    WR_EN <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask

  // one read strobe, answer taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge CLK_SYS);
    RD_EN <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD_EN <= 1'b0;
    ADDR <= ~a;
    #1;
    v = RVALID;
    d = RDATA;
  endtask
endmodule

// *** testbench/test_bcd_time_day_counters.sv ***
`timescale 1ns/1ps

module test_bcd_time_day_counters;
  import btd_pkg::*;

  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk_sys, rst_n, ce, wr_en, rd_en, rvalid, sec_tick;
  logic [7:0] addr, wdata, rdata, month_bcd, year_bcd;
  int error_cnt = 0;
  int n_tests = 0;

  btd_counters #(.TICK_COUNT(10)) u_dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .WR_EN(wr_en),
    .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .MONTH_BCD(month_bcd),
    .YEAR_BCD(year_bcd), .RDATA(rdata), .RVALID(rvalid),
    .SEC_TICK(sec_tick)
  );

  btd_host u_host (
    .CLK_SYS(clk_sys), .RDATA(rdata), .RVALID(rvalid), .CE(ce),
    .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata)
  );

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // read one byte and compare
  task check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    n_tests++;
    if (v !== 1'b1 || d !== exp) begin
      error_cnt++;
      $display("[ERR] %0t addr %h got %h exp %h", $time, a, d, exp);
    end
  endtask

  // wait for a tick pulse, return on the edge that advances time
  task wait_tick;
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      #1;
      i++;
    end while (sec_tick !== 1'b1 && i < 40);
    if (sec_tick !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t no second tick", $time);
      end_of_test();
    end
    @(posedge clk_sys);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // values after reset, seconds first before any tick
  task t_reset;
    check(ADDR_SECONDS, RST_SEC);
    check(ADDR_MINUTES, 8'h00);
    check(ADDR_HOURS, RST_HR);
    check(ADDR_DAYS, RST_DAY);
  endtask

  // unused bits written as ones read back as zero
  task t_mask;
    wait_tick();
    u_host.wr(ADDR_SECONDS, 8'hb0);
    check(ADDR_SECONDS, 8'h30);
    u_host.wr(ADDR_MINUTES, 8'hb7);
    check(ADDR_MINUTES, 8'h37);
    u_host.wr(ADDR_HOURS, 8'h92);
    check(ADDR_HOURS, 8'h12);
    u_host.wr(ADDR_DAYS, 8'hc5);
    check(ADDR_DAYS, 8'h05);
    check(8'h0c, 8'h00);
  endtask

  // clock enable low stalls time, then counting resumes with a bcd carry
  task t_freeze;
    wait_tick();
    u_host.wr(ADDR_SECONDS, 8'h09);
    u_host.freeze(30);
    check(ADDR_SECONDS, 8'h09);
    wait_tick();
    check(ADDR_SECONDS, 8'h10);
  endtask

  // load hh:59:59 on a given day, expect the carry one tick later
  task roll(input logic [7:0] h, dy, mo, yr, eh, ed);
    wait_tick();
    month_bcd <= mo;
    year_bcd <= yr;
    u_host.wr(ADDR_SECONDS, BCD_59);
    u_host.wr(ADDR_MINUTES, BCD_59);
    u_host.wr(ADDR_HOURS, h);
    u_host.wr(ADDR_DAYS, dy);
    wait_tick();
    check(ADDR_SECONDS, BCD_00);
    check(ADDR_MINUTES, BCD_00);
    check(ADDR_HOURS, eh);
    check(ADDR_DAYS, ed);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    month_bcd = 8'h01;
    year_bcd = 8'h01;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_freeze();
    roll(8'h09, 8'h15, 8'h01, 8'h01, 8'h10, 8'h15);
    roll(8'h23, 8'h31, 8'h12, 8'h01, 8'h00, 8'h01);
    roll(8'h23, 8'h30, 8'h04, 8'h01, 8'h00, 8'h01);
    roll(8'h23, 8'h30, 8'h05, 8'h01, 8'h00, 8'h31);
    roll(8'h23, 8'h28, 8'h02, 8'h24, 8'h00, 8'h29);
    roll(8'h23, 8'h28, 8'h02, 8'h00, 8'h00, 8'h29);
    roll(8'h23, 8'h28, 8'h02, 8'h23, 8'h00, 8'h01);
    roll(8'h23, 8'h29, 8'h02, 8'h24, 8'h00, 8'h01);
    roll(8'h71, 8'h15, 8'h01, 8'h01, 8'h52, 8'h16);
    roll(8'h51, 8'h15, 8'h01, 8'h01, 8'h72, 8'h15);
    roll(8'h72, 8'h15, 8'h01, 8'h01, 8'h61, 8'h15);
    end_of_test();
  end
endmodule
